/* core/tprb_bank.sv */
// Terminal parameter register bank with Avalon-MM slave
// Operation
// - One register set of 64 sixteen-bit words per logical channel.
// - Words split into process, type, manufacturer, user and extended areas.
// - Process words 0-7 are volatile RAM; 0-5 terminal specific.
// - Command writes parameter high, function low; read gives result, echoed number.
// - Type words 8-14 are fixed, readable, never written by user; word 15 is the alignment word.
// - Terminal kind word returns a fixed identifier.
// - Firmware version word holds ASCII major digit and minor character.
// - Shift register length word gives register count and bit length.
// - Channel count word gives number of logical channels.
// - Minimum length bytes; set MSB means control byte optional.
// - Layout type code 0x00 invalid, 0x01-0x08, 0x11-0x16 variable.
// - Alignment word pads terminal data to a byte boundary.
// - Manufacturer words non-volatile, writable only after code word.
// - User words non-volatile, write protected unless code word active.
// - Writing 0x1235 to key unlocks; any other value locks.
// - Key reads code word while unlocked, zero while locked.
// - Diagnostic word shows fault flags including parity errors.
// - Feature word selects terminal operating modes.
// - Extended area 48-63 is unimplemented.
// - Diagnostic bits: overflow, parity, framing, overrun, buffer full.
module tprb_bank
  import tprb_pkg::*;
(
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_n_i,
  // Avalon-MM slave, word addressed by byte address
  input  wire logic [tprb_pkg::ADDR_W-1:0] avs_address_i,
  input  wire logic                       avs_read_i,
  input  wire logic                       avs_write_i,
  input  wire logic [tprb_pkg::BUS_W-1:0] avs_writedata_i,
  input  wire logic [3:0]                 avs_byteenable_i,
  output logic [tprb_pkg::BUS_W-1:0]      avs_readdata_o,
  output logic                            avs_waitrequest_o,
  output logic [1:0]                      avs_response_o,
  // Process values from the terminal core (same clock)
  input  wire logic [tprb_pkg::DATA_W-1:0] pv_word0_i,
  input  wire logic [tprb_pkg::DATA_W-1:0] pv_word1_i,
  // Fault events from the serial receiver, one-cycle pulses
  input  wire logic [tprb_pkg::DIAG_BITS-1:0] diag_event_i,
  // Configuration outputs
  output logic [tprb_pkg::DATA_W-1:0]     operating_features_o,
  output logic [tprb_pkg::DATA_W-1:0]     byte_alignment_bits_o,
  output logic                            write_unlocked_o,
  output logic                            param_store_we_o,
  output logic [tprb_pkg::IDX_W-1:0]      param_store_idx_o,
  output logic [tprb_pkg::DATA_W-1:0]     param_store_data_o
);
  import tprb_pkg::*;

  // Word map of one channel, by word index
  //   0x00       process word from the terminal core, read only
  //   0x01       process word from the terminal core, read only
  //   0x02-0x05  volatile scratch words, always writable
  //   0x06       sticky fault flags, cleared by a read
  //   0x07       function command: number low, parameter or result high
  //   0x08-0x0d  fixed type words, writes dropped
  //   0x0e       unused type word, reads zero
  //   0x0f       alignment word, writable while unlocked
  //   0x10-0x1e  manufacturer words, writable while unlocked
  //   0x1f       code word register, always writable
  //   0x20       feature word, writable while unlocked
  //   0x21-0x2f  user words, writable while unlocked
  //   0x30-0x3f  unimplemented, reads zero and answers with an error
  //
  // Bus timing
  //   Every access costs one wait cycle: the request is taken on the
  //   first edge that sees it, and waitrequest drops for exactly the
  //   following cycle so the master may release after that edge.
  //   Read data and response are registered on the taking edge and
  //   stand until replaced: read data by the next read, the response by the next access of either kind.
  //   The ack flag masks the held request in the answer cycle, so a
  //   held write never lands twice and a held read of the fault word
  //   never clears flags raised during the answer cycle.
  //
  // Protection
  //   The unlock state is the code word compare itself, not a copy, so
  //   a write straight after the unlocking write already sees it open.
  //   The registered unlock output runs one cycle behind the compare.
  //   A key write needs both low byte lanes, so a half word write can
  //   never leave a key that is neither zero nor the code word.
  //
  // Non-volatile store
  //   Parameter words are kept here as a shadow and every accepted
  //   write is mirrored to the store port as one full merged word, so
  //   the store never needs a read-modify-write of its own.
  //   The shadow is not reset: after power-up each word reads unknown
  //   until both of its bytes have been written over the bus.
  //
  // Limitations
  //   Misaligned byte addresses are answered with an error and change
  //   nothing. Upper byte lanes and upper write data are ignored.

  // Local index and code constants
  localparam logic [IDX_W-1:0] PV_IDX0      = 6'h00;
  localparam logic [IDX_W-1:0] PV_IDX1      = 6'h01;
  localparam logic [IDX_W-1:0] PV_RAM_FIRST = 6'h02;
  localparam logic [1:0]       RSP_OKAY     = 2'h0;
  localparam logic [1:0]       RSP_SLVERR   = 2'h2;
  localparam logic [1:0]       BE_WORD      = 2'h3;
  localparam logic [1:0]       LANE_OFFSET  = 2'h0;

  logic [DATA_W-1:0]    param_mem [NUM_WORDS];
  logic [DATA_W-1:0]    pv_mem [NUM_WORDS];
  logic [DATA_W-1:0]    write_unlock_key;
  logic [DATA_W-1:0]    operating_features;
  logic [DATA_W-1:0]    byte_alignment_bits;
  logic [DIAG_BITS-1:0] diagnostic_flags;
  logic [7:0]           fn_number;
  logic [7:0]           fn_result;
  logic                 ack;
  logic [IDX_W-1:0]     idx;
  logic                 word_ok;
  logic                 req;
  logic                 wr_go;
  logic                 rd_go;
  logic [DATA_W-1:0]    wdata;
  logic [DATA_W-1:0]    next_rdata;
  logic                 unlocked;
  logic                 in_param;
  logic                 param_wr;

  // Word decode: byte address is four times the word index
  assign idx      = avs_address_i[ADDR_W-1:2];
  assign word_ok  = (avs_address_i[1:0] == LANE_OFFSET);
  assign req      = (avs_read_i | avs_write_i) & ~ack;
  assign wr_go    = avs_write_i & ~ack;
  assign rd_go    = avs_read_i & ~ack;
  // Low half byte lanes merged over current content is not needed: lanes gate per byte below
  assign wdata    = avs_writedata_i[DATA_W-1:0];
  assign unlocked = (write_unlock_key == UNLOCK_CODE);
  assign in_param = (idx >= IDX_MFR_FIRST) && (idx <= IDX_USR_LAST) && (idx != IDX_KEY) && (idx != IDX_FEAT);
  assign param_wr = wr_go & word_ok & in_param & unlocked;

  // Answer one cycle after the request is seen, waitrequest low on that cycle
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      ack <= 1'b0;
    else
      ack <= req;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= ~req;
  end

  // Misaligned or unimplemented (0x30-0x3f) answers SLVERR; unused word 0x0e answers OKAY
  // Registered on the same edge as the read data, and on writes as well
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      avs_response_o <= RSP_OKAY;
    else if (req)
      avs_response_o <= (!word_ok || idx >= IDX_EXT_FIRST) ? RSP_SLVERR : RSP_OKAY;
  end

  // Code word register, cleared at reset
  // Any value but the code word stores zero and locks again
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      write_unlock_key <= 16'h0000;
    else if (wr_go && word_ok && idx == IDX_KEY && avs_byteenable_i[1:0] == BE_WORD)
      write_unlock_key <= (wdata == UNLOCK_CODE) ? UNLOCK_CODE : 16'h0000;
  end

  // Feature and alignment registers
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      operating_features  <= FEAT_RST;
      byte_alignment_bits <= ALIGN_RST;
    end
    else if (wr_go && word_ok && unlocked)
    begin
      if (idx == IDX_FEAT)
      begin
        if (avs_byteenable_i[0]) operating_features[7:0]  <= wdata[7:0];
        if (avs_byteenable_i[1]) operating_features[15:8] <= wdata[15:8];
      end
      if (idx == IDX_ALIGN)
      begin
        if (avs_byteenable_i[0]) byte_alignment_bits[7:0]  <= wdata[7:0];
        if (avs_byteenable_i[1]) byte_alignment_bits[15:8] <= wdata[15:8];
      end
    end
  end

  // Parameter words, mirrored out to the non-volatile store
  always_ff @(posedge core_clk_i)
  begin
    if (param_wr)
    begin
      if (avs_byteenable_i[0]) param_mem[idx][7:0]  <= wdata[7:0];
      if (avs_byteenable_i[1]) param_mem[idx][15:8] <= wdata[15:8];
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      param_store_we_o   <= 1'b0;
      param_store_idx_o  <= 6'h00;
      param_store_data_o <= 16'h0000;
    end
    else
    begin
      param_store_we_o <= param_wr;
      if (param_wr)
      begin
        param_store_idx_o  <= idx;
        param_store_data_o <= {avs_byteenable_i[1] ? wdata[15:8] : param_mem[idx][15:8],
                               avs_byteenable_i[0] ? wdata[7:0]  : param_mem[idx][7:0]};
      end
    end
  end

  // Volatile process words 2..5, software writable
  // No reset: volatile scratch, content undefined after power-up
  always_ff @(posedge core_clk_i)
  begin
    if (wr_go && word_ok && idx >= PV_RAM_FIRST && idx < IDX_DIAG)
    begin
      if (avs_byteenable_i[0]) pv_mem[idx][7:0]  <= wdata[7:0];
      if (avs_byteenable_i[1]) pv_mem[idx][15:8] <= wdata[15:8];
    end
  end

  // Command register: number stored, result computed per function
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      fn_number <= 8'h00;
      fn_result <= 8'h00;
    end
    else if (wr_go && word_ok && idx == IDX_CMD)
    begin
      if (avs_byteenable_i[0])
        fn_number <= wdata[7:0];
      fn_result <= (wdata[7:0] == FN_ECHO) ? wdata[15:8] : 8'h00;
    end
  end

  // Sticky fault flags, event wins over a clear by read
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      diagnostic_flags <= '0;
    else if (rd_go && word_ok && idx == IDX_DIAG)
      diagnostic_flags <= diag_event_i;
    else
      diagnostic_flags <= diagnostic_flags | diag_event_i;
  end

  // Read multiplexer
  always_comb
  begin
    next_rdata = UNIMPL_VAL;
    if (idx == PV_IDX0)
      next_rdata = pv_word0_i;
    else if (idx == PV_IDX1)
      next_rdata = pv_word1_i;
    else if (idx < IDX_DIAG)
      next_rdata = pv_mem[idx];
    else if (idx == IDX_DIAG)
      next_rdata = {{(DATA_W-DIAG_BITS){1'b0}}, diagnostic_flags};
    else if (idx == IDX_CMD)
      next_rdata = {fn_result, fn_number};
    else if (idx == IDX_KIND)
      next_rdata = KIND_VAL;
    else if (idx == IDX_FWVER)
      next_rdata = FWVER_VAL;
    else if (idx == IDX_SRLEN)
      next_rdata = SRLEN_VAL;
    else if (idx == IDX_CHCNT)
      next_rdata = CHCNT_VAL;
    else if (idx == IDX_MINLEN)
      next_rdata = MINLEN_VAL;
    else if (idx == IDX_LAYOUT)
      next_rdata = LAYOUT_VAL;
    else if (idx == IDX_ALIGN)
      next_rdata = byte_alignment_bits;
    else if (idx == IDX_KEY)
      next_rdata = unlocked ? UNLOCK_CODE : 16'h0000;
    else if (idx == IDX_FEAT)
      next_rdata = operating_features;
    else if (idx >= IDX_MFR_FIRST && idx <= IDX_USR_LAST)
      next_rdata = param_mem[idx];
    if (!word_ok)
      next_rdata = UNIMPL_VAL;
  end

  // Registered read data, upper half reads zero
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      avs_readdata_o <= '0;
    else if (rd_go)
      avs_readdata_o <= {16'h0000, next_rdata};
  end

  // Configuration outputs
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      operating_features_o  <= FEAT_RST;
      byte_alignment_bits_o <= ALIGN_RST;
      write_unlocked_o      <= 1'b0;
    end
    else
    begin
      operating_features_o  <= operating_features;
      byte_alignment_bits_o <= byte_alignment_bits;
      write_unlocked_o      <= unlocked;
    end
  end
endmodule // tprb_bank

/* core/tprb_pkg.sv */
// Package with register map, fields and reset values of the terminal parameter register bank
package tprb_pkg;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned BUS_W         = 32;
  localparam int unsigned IDX_W         = 6;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned NUM_WORDS     = 64;
  // Area bounds by word index
  localparam logic [5:0] IDX_PV_LAST    = 6'h07;
  localparam logic [5:0] IDX_TYPE_FIRST = 6'h08;
  localparam logic [5:0] IDX_TYPE_LAST  = 6'h0f;
  localparam logic [5:0] IDX_MFR_FIRST  = 6'h10;
  localparam logic [5:0] IDX_MFR_LAST   = 6'h1e;
  localparam logic [5:0] IDX_USR_FIRST  = 6'h1f;
  localparam logic [5:0] IDX_USR_LAST   = 6'h2f;
  localparam logic [5:0] IDX_EXT_FIRST  = 6'h30;
  // Named registers
  localparam logic [5:0] IDX_DIAG       = 6'h06;
  localparam logic [5:0] IDX_CMD        = 6'h07;
  localparam logic [5:0] IDX_KIND       = 6'h08;
  localparam logic [5:0] IDX_FWVER      = 6'h09;
  localparam logic [5:0] IDX_SRLEN      = 6'h0a;
  localparam logic [5:0] IDX_CHCNT      = 6'h0b;
  localparam logic [5:0] IDX_MINLEN     = 6'h0c;
  localparam logic [5:0] IDX_LAYOUT     = 6'h0d;
  localparam logic [5:0] IDX_ALIGN      = 6'h0f;
  localparam logic [5:0] IDX_KEY        = 6'h1f;
  localparam logic [5:0] IDX_FEAT       = 6'h20;
  // Unlock code word
  localparam logic [15:0] UNLOCK_CODE   = 16'h1235;
  // Type register contents (identity values arbitrary)
  localparam logic [15:0] KIND_VAL      = 16'h0a5a;  // Arbitrary value
  localparam logic [15:0] FWVER_VAL     = 16'h3141;  // ASCII '1','A'
  localparam logic [15:0] SRLEN_VAL     = 16'h0120;  // One shift register, 32 bits
  localparam logic [15:0] CHCNT_VAL     = 16'h0001;
  localparam logic [15:0] MINLEN_VAL    = 16'h1818;
  localparam logic [15:0] LAYOUT_VAL    = 16'h0002;  // Byte structure
  localparam logic [15:0] FEAT_RST      = 16'h0003;
  localparam logic [15:0] ALIGN_RST     = 16'h0000;
  // Function command: echo function parameter as result
  localparam logic [7:0]  FN_ECHO       = 8'h01;
  // Diagnostic flag bits
  localparam int unsigned DIAG_OVF      = 0;
  localparam int unsigned DIAG_PAR      = 1;
  localparam int unsigned DIAG_FRM      = 2;
  localparam int unsigned DIAG_OVR      = 3;
  localparam int unsigned DIAG_FULL     = 4;
  localparam int unsigned DIAG_BITS     = 5;
  // Read answer for unimplemented area
  localparam logic [15:0] UNIMPL_VAL    = 16'h0000;
endpackage : tprb_pkg

/* sim/tprb_bank_chk.sv */
// Checker for the register bank bus timing and protection
module tprb_bank_chk
  import tprb_pkg::*;
(
  input wire logic              core_clk_i,
  input wire logic              rst_n_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic              avs_read_i,
  input wire logic              avs_write_i,
  input wire logic [BUS_W-1:0]  avs_writedata_i,
  input wire logic [3:0]        avs_byteenable_i,
  input wire logic [BUS_W-1:0]  avs_readdata_o,
  input wire logic              avs_waitrequest_o,
  input wire logic [1:0]        avs_response_o,
  input wire logic [DATA_W-1:0] operating_features_o,
  input wire logic              write_unlocked_o,
  input wire logic              param_store_we_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Accepted access and its word index
  wire       acc = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
  wire [5:0] idx = avs_address_i[7:2];
  // Fixed type word contents
  function automatic logic [15:0] tval(input logic [5:0] i);
    case (i)
      IDX_KIND:  return KIND_VAL;
      IDX_FWVER: return FWVER_VAL;
      IDX_SRLEN: return SRLEN_VAL;
      IDX_CHCNT: return CHCNT_VAL;
      IDX_MINLEN: return MINLEN_VAL;
      default:   return LAYOUT_VAL;
    endcase
  endfunction
  sequence key_wr_s;
    acc && avs_write_i && idx == IDX_KEY && avs_byteenable_i[1:0] == 2'b11;
  endsequence
  sequence key_rd_s;
    acc && avs_read_i && idx == IDX_KEY && write_unlocked_o == $past(write_unlocked_o);
  endsequence
  AST_ONE_WAIT: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("answer not one cycle after request");
  AST_WAIT_PULSE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  AST_EXT_ERR: assert property (acc && idx >= IDX_EXT_FIRST |-> avs_response_o == 2'b10)
    else $error("extended area not flagged");
  AST_TYPE_FIX: assert property (acc && avs_read_i && idx inside {[8:13]} |-> avs_readdata_o == {16'h0, tval(idx)})
    else $error("type word value wrong");
  AST_KEY_ZERO: assert property (key_rd_s ##0 !write_unlocked_o |-> avs_readdata_o == 32'h0)
    else $error("locked key read not zero");
  AST_KEY_ECHO: assert property (key_rd_s ##0 write_unlocked_o |-> avs_readdata_o == {16'h0, UNLOCK_CODE})
    else $error("unlocked key read wrong");
  AST_UNLOCK: assert property (key_wr_s ##0 avs_writedata_i[15:0] == UNLOCK_CODE |-> ##[1:2] write_unlocked_o)
    else $error("code word did not unlock");
  AST_LOCK: assert property (key_wr_s ##0 avs_writedata_i[15:0] != UNLOCK_CODE |-> ##[1:2] !write_unlocked_o)
    else $error("other value did not lock");
  AST_STORE_GATE: assert property (param_store_we_o |-> $past(write_unlocked_o))
    else $error("store written while locked");
  AST_FEAT_GATE: assert property ($changed(operating_features_o) |-> $past(write_unlocked_o))
    else $error("features changed while locked");
endmodule // tprb_bank_chk

bind tprb_bank tprb_bank_chk u_chk (.core_clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .avs_response_o,
  .operating_features_o, .write_unlocked_o, .param_store_we_o);

/* sim/tprb_coupler.sv */
// Coupler model: register-mode master on the Avalon-MM bus
module tprb_coupler (
  input  wire logic        clk_i,
  input  wire logic [31:0] readdata_i,
  input  wire logic        waitrequest_i,
  input  wire logic [1:0]  response_i,
  output logic [7:0]       address_o,
  output logic             read_o,
  output logic             write_o,
  output logic [31:0]      writedata_o,
  output logic [3:0]       byteenable_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] rsp;
  // Idle bus, both byte lanes of the word selected
  initial
  begin
    {address_o, read_o, write_o, writedata_o} = '0;
    byteenable_o = 4'h3;
  end
  // Register access only in register mode, held until waitrequest low
  task automatic wr(input logic [5:0] i, input logic [15:0] d);
    address_o <= {i, 2'b00};
    writedata_o <= {16'h0, d};
    write_o <= 1'b1;
    do @(posedge clk_i); while (waitrequest_i !== 1'b0);
    write_o <= 1'b0;
    writedata_o <= ~writedata_o;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [5:0] i, output logic [31:0] d);
    address_o <= {i, 2'b00};
    read_o <= 1'b1;
    do @(posedge clk_i); while (waitrequest_i !== 1'b0);
    d = readdata_i;
    rsp = response_i;
    read_o <= 1'b0;
    address_o <= ~address_o;
    @(posedge clk_i);
  endtask
endmodule // tprb_coupler

/* sim/terminal_parameter_register_bank_tb_top.sv */
// Testbench top for the terminal parameter register bank
module terminal_parameter_register_bank_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import tprb_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, rd, wr, wreq, unl, swe;
  logic [15:0] pv0 = '0, pv1 = '0, feat, algn, sdat;
  logic [4:0]  diag = '0;
  logic [7:0]  adr;
  logic [31:0] wd, rdata, v;
  logic [3:0]  be;
  logic [1:0]  resp;
  logic [5:0]  sidx;
  logic [21:0] st;
  int          err_count = 0, checks_done = 0, cyc = 0, store_cnt = 0, n;
  always #12.5 clk = ~clk;
  tprb_coupler u_cpl (.clk_i(clk), .readdata_i(rdata), .waitrequest_i(wreq), .response_i(resp),
    .address_o(adr), .read_o(rd), .write_o(wr), .writedata_o(wd), .byteenable_o(be));
  tprb_bank u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .avs_response_o(resp), .pv_word0_i(pv0), .pv_word1_i(pv1),
    .diag_event_i(diag), .operating_features_o(feat), .byte_alignment_bits_o(algn),
    .write_unlocked_o(unl), .param_store_we_o(swe), .param_store_idx_o(sidx), .param_store_data_o(sdat));
  // Store pulse monitor and run time limit
  always @(posedge clk)
  begin
    cyc++;
    if (swe === 1'b1)
    begin
      store_cnt++;
      st = {sidx, sdat};
    end
    if (cyc == 3000)
    begin
      err_count++;
      report_and_stop;
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rdc(input string nm, input logic [5:0] i, input logic [15:0] exp);
    u_cpl.rd(i, v);
    chk(nm, v, {16'h0, exp});
  endtask
  task automatic t_reset;
    chk("features", 32'(feat), 32'(FEAT_RST));
    chk("align", 32'(algn), 32'(ALIGN_RST));
    chk("unlocked", 32'(unl), 32'h0);
    rdc("key", IDX_KEY, 16'h0);
    rdc("kind", IDX_KIND, KIND_VAL);
    chk("kind resp", 32'(u_cpl.rsp), 32'h0);
    rdc("version", IDX_FWVER, FWVER_VAL);
    rdc("srlen", IDX_SRLEN, SRLEN_VAL);
    rdc("chcnt", IDX_CHCNT, CHCNT_VAL);
    rdc("minlen", IDX_MINLEN, MINLEN_VAL);
    rdc("layout", IDX_LAYOUT, LAYOUT_VAL);
    $display("Test reset done");
  endtask
  task automatic t_protect;
    u_cpl.wr(IDX_KIND, 16'hffff);
    rdc("kind ro", IDX_KIND, KIND_VAL);
    u_cpl.wr(IDX_FEAT, 16'h00f0);
    chk("feat locked", 32'(feat), 32'(FEAT_RST));
    u_cpl.wr(IDX_ALIGN, 16'h0005);
    chk("align locked", 32'(algn), 32'(ALIGN_RST));
    n = store_cnt;
    u_cpl.wr(6'h10, 16'h1111);
    @(posedge clk);
    chk("store locked", 32'(store_cnt), 32'(n));
    u_cpl.wr(IDX_KEY, UNLOCK_CODE);
    rdc("key open", IDX_KEY, UNLOCK_CODE);
    chk("unlocked", 32'(unl), 32'h1);
    u_cpl.wr(6'h10, 16'h2222);
    @(posedge clk);
    chk("store", 32'(st), 32'({6'h10, 16'h2222}));
    u_cpl.wr(6'h21, 16'h3333);
    rdc("user", 6'h21, 16'h3333);
    u_cpl.wr(IDX_FEAT, 16'h00f0);
    chk("feat open", 32'(feat), 32'h00f0);
    u_cpl.wr(IDX_ALIGN, 16'h0005);
    chk("align open", 32'(algn), 32'h0005);
    rdc("align rd", IDX_ALIGN, 16'h0005);
    u_cpl.wr(IDX_KEY, 16'h1234);
    rdc("key shut", IDX_KEY, 16'h0);
    u_cpl.wr(6'h21, 16'h4444);
    rdc("user kept", 6'h21, 16'h3333);
    $display("Test protect done");
  endtask
  task automatic t_cmd_pv;
    u_cpl.wr(IDX_CMD, {8'h5a, FN_ECHO});
    rdc("cmd echo", IDX_CMD, {8'h5a, FN_ECHO});
    u_cpl.wr(IDX_CMD, 16'h7702);
    rdc("cmd other", IDX_CMD, 16'h0002);
    pv0 <= 16'hbeef;
    pv1 <= 16'h0420;
    diag <= 5'h1f;
    @(posedge clk);
    diag <= 5'h00;
    rdc("pv0", 6'h00, 16'hbeef);
    rdc("pv1", 6'h01, 16'h0420);
    u_cpl.wr(6'h02, 16'h5aa5);
    rdc("pv2", 6'h02, 16'h5aa5);
    rdc("diag", IDX_DIAG, 16'h001f);
    rdc("diag clr", IDX_DIAG, 16'h0000);
    rdc("ext", 6'h30, 16'h0);
    chk("ext resp", 32'(u_cpl.rsp), 32'h2);
    rdc("ext top", 6'h3f, 16'h0);
    chk("ext top resp", 32'(u_cpl.rsp), 32'h2);
    $display("Test command and process done");
  endtask
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_protect;
    t_cmd_pv;
    report_and_stop;
  end
endmodule // terminal_parameter_register_bank_tb_top
